// *** hdl/pfbp_pkg.sv ***
// Package with constants and types for the fetch-ahead unit.
// Behaviour
// - Eight-entry FIFO holds instruction and address.
// - One instruction leaves per transfer, in order.
// - Own program counter drives fetch address.
// - Predict only while enable bit is one.
// - Prediction uses encoding only, no history.
// - Link-branch predicted only when condition always.
// - Prefetch-aborted instruction is never predicted.
// - Condition 1111 or non-branch passes unchanged.
// - Always-condition branch is predicted taken.
// - Backward taken, forward not taken otherwise.
// - Predicted link-branch emits register move first.
// - Save fall-through or target as recovery address.
// - Check flags; on error refetch and cancel.
// - Disabling prediction keeps launched speculation running.
// - Barrier operation flushes the prefetch buffer.
package pfbp_pkg;
    localparam int DEPTH = 8;
    localparam int PTR_W = 3;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam logic [3:0] COND_ALWAYS = 4'hE;
    localparam logic [3:0] COND_NEVER = 4'hF;
    localparam logic [2:0] BRANCH_CLASS = 3'h5;
    localparam logic [3:0] LINK_CLASS = 4'hB;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] PIPE_AHEAD = 32'h0000_0008;
    localparam int PRED_EN_BIT = 11;
    // Register-move op: copy return address into link register.
    localparam logic [31:0] LINK_MOVE_OP = 32'hE1A0_E00F;
    localparam logic [31:0] PLAIN_BRANCH_MASK = 32'hFEFF_FFFF;
    typedef enum logic [1:0] {PFBP_IDLE, PFBP_PENDING} pfbp_spec_t;
endpackage

// *** hdl/pfbp_fifo_if.sv ***
// Interface carrying the buffer write and read sides.
`timescale 1ns/1ps
interface pfbp_fifo_if;
    logic wr_en;
    logic [64:0] wr_data;
    logic rd_en;
    logic [64:0] rd_data;
    logic [3:0] count;
    logic flush;
    modport ctrl (output wr_en, output wr_data, output rd_en, output flush,
        input rd_data, input count);
    modport mem (input wr_en, input wr_data, input rd_en, input flush,
        output rd_data, output count);
endinterface

// *** hdl/pfbp_fifo.sv ***
// Instruction and address FIFO of the fetch-ahead unit.
`timescale 1ns/1ps
module pfbp_fifo #(
    parameter int DEPTH = pfbp_pkg::DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    pfbp_fifo_if.mem f
);
    // Each entry holds the abort flag, the instruction and its address.
    logic [64:0] mem_r [DEPTH];
    logic [2:0] wp_r;
    logic [2:0] rp_r;
    logic [3:0] cnt_r;
    wire do_wr = f.wr_en && (cnt_r < 4'(DEPTH));
    wire do_rd = f.rd_en && (cnt_r != 4'h0);
    assign f.rd_data = mem_r[rp_r];
    assign f.count = cnt_r;
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_r[wp_r] <= f.wr_data;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || f.flush) begin
            wp_r <= 3'h0;
            rp_r <= 3'h0;
            cnt_r <= 4'h0;
        end else begin
            wp_r <= wp_r + 3'(do_wr);
            rp_r <= rp_r + 3'(do_rd);
            cnt_r <= cnt_r + 4'(do_wr) - 4'(do_rd);
        end
    end
endmodule

// *** hdl/pfbp_top.sv ***
// Fetch-ahead unit: program counter, buffer, static predictor, recovery.
`timescale 1ns/1ps
module pfbp_top (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Control
    input wire logic [31:0] SYS_CTRL_I,
    input wire logic BARRIER_I,
    // Instruction memory
    output logic [31:0] FETCH_ADDR_O,
    output logic FETCH_REQ_O,
    input wire logic FETCH_VALID_I,
    input wire logic [31:0] FETCH_DATA_I,
    input wire logic FETCH_ABORT_I,
    // Core side
    output logic CORE_VALID_O,
    output logic [31:0] CORE_INSTR_O,
    output logic [31:0] CORE_ADDR_O,
    output logic CORE_ABORT_O,
    input wire logic CORE_READY_I,
    // Prediction resolution from core condition codes
    input wire logic RESOLVE_I,
    input wire logic COND_PASS_I,
    output logic CANCEL_O
);
    pfbp_fifo_if fif ();
    pfbp_fifo u_fifo (.clk(REF_CLK_I), .rst(RST_I), .f(fif));

    logic [31:0] pc_r;
    logic [31:0] pc_nxt;
    logic req_r;
    logic [31:0] alt_r;
    logic pred_taken_r;
    pfbp_pkg::pfbp_spec_t spec_r;
    logic link_pend_r;
    logic [31:0] out_i_r;
    logic [31:0] out_a_r;
    logic out_ab_r;
    logic out_v_r;
    logic cancel_r;

    wire [31:0] in_instr = FETCH_DATA_I;
    wire [3:0] in_cond = in_instr[31:28];
    // Offset is word-scaled and signed; target seen from the pipeline.
    wire [31:0] in_target = pc_r + pfbp_pkg::PIPE_AHEAD
        + {{6{in_instr[23]}}, in_instr[23:0], 2'b00};
    wire [31:0] fall_thru = pc_r + pfbp_pkg::WORD_STEP;
    wire pred_on = SYS_CTRL_I[pfbp_pkg::PRED_EN_BIT];
    wire is_branch = (in_instr[27:25] == pfbp_pkg::BRANCH_CLASS)
        && (in_cond != pfbp_pkg::COND_NEVER);
    wire is_link = in_instr[27:24] == pfbp_pkg::LINK_CLASS;
    // The refetched word after a split is judged as a plain branch.
    wire is_link_eff = is_link && !link_pend_r;
    wire is_always = in_cond == pfbp_pkg::COND_ALWAYS;
    wire eligible = FETCH_VALID_I && pred_on && !FETCH_ABORT_I && is_branch
        && !(is_link && !is_always) && (spec_r == pfbp_pkg::PFBP_IDLE);
    wire take = is_always || (!in_instr[24] && in_instr[23]);
    wire space = fif.count < 4'(pfbp_pkg::DEPTH - 1);
    wire mispred = RESOLVE_I && (spec_r == pfbp_pkg::PFBP_PENDING)
        && (COND_PASS_I != pred_taken_r);
    wire flush = mispred || BARRIER_I;
    wire pop = (!out_v_r || CORE_READY_I) && (fif.count != 4'h0) && !flush;
    wire accept = FETCH_VALID_I && req_r && !flush;
    // Predicted link: the move goes in now, the plain branch is refetched and predicted at the next accepted fetch.
    wire split = accept && eligible && is_link_eff;
    wire pred_now = accept && eligible && !is_link_eff;
    wire [31:0] plain_branch = in_instr & pfbp_pkg::PLAIN_BRANCH_MASK;

    // link part as register move
    // Predicted plain branches are removed from the core's stream.
    assign fif.wr_en = accept && !pred_now;
    assign fif.wr_data = split ? {1'b0, pfbp_pkg::LINK_MOVE_OP, pc_r}
        : {FETCH_ABORT_I, in_instr, pc_r};
    assign fif.rd_en = pop;
    assign fif.flush = flush;

    always_comb begin
        pc_nxt = pc_r;
        if (mispred) begin
            pc_nxt = alt_r;
        end else if (BARRIER_I) begin
            pc_nxt = pc_r;
        end else if (pred_now) begin
            pc_nxt = take ? in_target : fall_thru;
        end else if (accept && !split) begin
            pc_nxt = fall_thru;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            pc_r <= pfbp_pkg::RESET_PC;
            req_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            req_r <= space && !flush;
        end
    end

    // Plain-branch half of a split link branch is re-evaluated from memory data.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || flush) begin
            link_pend_r <= 1'b0;
        end else begin
            // Held until the branch half is taken, so a stall cannot split twice.
            link_pend_r <= split || (link_pend_r && !accept);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            spec_r <= pfbp_pkg::PFBP_IDLE;
            alt_r <= pfbp_pkg::RESET_PC;
            pred_taken_r <= 1'b0;
        end else if (flush || RESOLVE_I) begin
            spec_r <= pfbp_pkg::PFBP_IDLE;
        end else if (pred_now && !is_always) begin
            spec_r <= pfbp_pkg::PFBP_PENDING;
            alt_r <= take ? fall_thru : in_target;
            pred_taken_r <= take;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || flush) begin
            out_v_r <= 1'b0;
            out_i_r <= 32'h0000_0000;
            out_a_r <= 32'h0000_0000;
            out_ab_r <= 1'b0;
        end else if (pop) begin
            out_v_r <= 1'b1;
            out_i_r <= fif.rd_data[63:32];
            out_a_r <= fif.rd_data[31:0];
            out_ab_r <= fif.rd_data[64];
        end else if (CORE_READY_I) begin
            out_v_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            cancel_r <= 1'b0;
        end else begin
            cancel_r <= mispred;
        end
    end

    assign FETCH_ADDR_O = pc_r;
    assign FETCH_REQ_O = req_r;
    assign CORE_VALID_O = out_v_r;
    assign CORE_INSTR_O = out_i_r;
    assign CORE_ADDR_O = out_a_r;
    assign CORE_ABORT_O = out_ab_r;
    assign CANCEL_O = cancel_r;
    wire unused_ok = &{1'b0, plain_branch};
endmodule

// *** verification/pfbp_mem_model.sv ***
// Instruction memory model that answers fetches promptly or with stalls.
`timescale 1ns/1ps
module pfbp_mem_model #(
    parameter logic [31:0] BR_ADDR = 32'h0000_0010,
    parameter logic [31:0] ABORT_ADDR = 32'h0000_0020
) (
    // Fetch request
    input wire logic [31:0] addr_i,
    input wire logic req_i,
    input wire logic slow_i,
    input wire logic [31:0] br_word_i,
    // Answer
    output logic valid_o,
    output logic [31:0] data_o,
    output logic abort_o
);
    logic [31:0] word;
    assign word = (addr_i == BR_ADDR) ? br_word_i : {16'hE280, addr_i[15:0]};
    assign valid_o = req_i && !slow_i;
    // A word not on offer shows its inverse, so stale data cannot pass as fresh.
    assign data_o = valid_o ? word : ~word;
    assign abort_o = valid_o && (addr_i == ABORT_ADDR);
endmodule

// *** verification/pfbp_assertions.sv ***
// Port checker for the fetch-ahead unit.
`timescale 1ns/1ps
module pfbp_assertions (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Inputs watched
    input wire logic [31:0] SYS_CTRL_I,
    input wire logic BARRIER_I,
    input wire logic FETCH_VALID_I,
    input wire logic CORE_READY_I,
    input wire logic RESOLVE_I,
    // Outputs watched
    input wire logic [31:0] FETCH_ADDR_O,
    input wire logic FETCH_REQ_O,
    input wire logic CORE_VALID_O,
    input wire logic [31:0] CORE_INSTR_O,
    input wire logic [31:0] CORE_ADDR_O,
    input wire logic CORE_ABORT_O,
    input wire logic CANCEL_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_take;
        FETCH_REQ_O && FETCH_VALID_I && !BARRIER_I && !RESOLVE_I;
    endsequence
    sequence s_stall;
        CORE_VALID_O && !CORE_READY_I && !BARRIER_I && !RESOLVE_I;
    endsequence
    property p_rst;
        disable iff (1'b0) RST_I |=> !CORE_VALID_O && FETCH_ADDR_O == 32'h0 && !CANCEL_O;
    endproperty
    property p_req;
        $fell(RST_I) |=> FETCH_REQ_O;
    endproperty
    property p_pc;
        s_take ##0 !SYS_CTRL_I[11] |=> FETCH_ADDR_O == $past(FETCH_ADDR_O) + 32'h4;
    endproperty
    property p_hold;
        s_stall |=> CORE_VALID_O && $stable(CORE_INSTR_O) && $stable(CORE_ADDR_O);
    endproperty
    property p_cancel;
        CANCEL_O |-> $past(RESOLVE_I);
    endproperty
    property p_pulse;
        CANCEL_O |=> !CANCEL_O;
    endproperty
    property p_abort;
        CORE_VALID_O && CORE_ABORT_O |-> CORE_INSTR_O != pfbp_pkg::LINK_MOVE_OP;
    endproperty
    property p_bar;
        BARRIER_I |-> ##2 !CORE_VALID_O;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_req: assert property (p_req) else $error("no fetch after reset");
    a_pc: assert property (p_pc) else $error("fetch address not stepped");
    a_hold: assert property (p_hold) else $error("core word changed while stalled");
    a_cancel: assert property (p_cancel) else $error("cancel without resolve");
    a_pulse: assert property (p_pulse) else $error("cancel longer than a cycle");
    a_abort: assert property (p_abort) else $error("aborted word was split");
    a_bar: assert property (p_bar) else $error("barrier left words");
endmodule
bind pfbp_top pfbp_assertions chk (.REF_CLK_I, .RST_I, .SYS_CTRL_I, .BARRIER_I,
    .FETCH_VALID_I, .CORE_READY_I, .RESOLVE_I, .FETCH_ADDR_O, .FETCH_REQ_O,
    .CORE_VALID_O, .CORE_INSTR_O, .CORE_ADDR_O, .CORE_ABORT_O, .CANCEL_O);

// *** verification/testbench.sv ***
// Self-checking bench for the fetch-ahead unit.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] ctrl = 32'h0;
    logic bar = 1'b0;
    logic rdy = 1'b1;
    logic res = 1'b0;
    logic slow = 1'b0;
    logic cp = 1'b1;
    logic [31:0] br = 32'hEA00_000C;
    logic [31:0] fa, fd, ci, ca;
    logic fr, fv, fab, cv, cab, cx;
    logic [64:0] q[$];
    int err_count = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    pfbp_top dut (.REF_CLK_I(clk), .RST_I(rst), .SYS_CTRL_I(ctrl), .BARRIER_I(bar),
        .FETCH_ADDR_O(fa), .FETCH_REQ_O(fr), .FETCH_VALID_I(fv), .FETCH_DATA_I(fd),
        .FETCH_ABORT_I(fab), .CORE_VALID_O(cv), .CORE_INSTR_O(ci), .CORE_ADDR_O(ca),
        .CORE_ABORT_O(cab), .CORE_READY_I(rdy), .RESOLVE_I(res), .COND_PASS_I(cp),
        .CANCEL_O(cx));
    pfbp_mem_model mem (.addr_i(fa), .req_i(fr), .slow_i(slow), .br_word_i(br),
        .valid_o(fv), .data_o(fd), .abort_o(fab));
    always @(posedge clk) begin
        if (!rst && cv === 1'b1 && rdy) begin
            q.push_back({cab, ca, ci});
        end
    end
    function automatic logic [31:0] w(input logic [31:0] a);
        return (a == 32'h10) ? br : {16'hE280, a[15:0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Resets, then stalls core and memory in turn until n words reach the core.
    task automatic run(input int n);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        q.delete();
        rst = 1'b0;
        for (int k = 0; k < 400 && q.size() < n; k++) begin
            @(negedge clk);
            rdy = (k % 3) != 1;
            slow = (k % 5) == 2;
        end
        rdy = 1'b1;
    endtask
    task automatic t_plain();
        ctrl = 32'h0;
        run(9);
        for (int i = 0; i < 9; i++) begin
            chk("addr", 32'(i * 4), q[i][63:32]);
            chk("instr", w(32'(i * 4)), q[i][31:0]);
            chk("abort", 32'(i == 8), 32'(q[i][64]));
        end
        $display("test plain done");
    endtask
    task automatic t_pred();
        logic [31:0] bw [5] = '{32'hEA00_000C, 32'hEB00_000C, 32'h0B00_000C, 32'hFA00_000C,
            32'h0A00_000C};
        logic [31:0] ew [5] = '{32'hE280_0048, pfbp_pkg::LINK_MOVE_OP, 32'h0B00_000C,
            32'hFA00_000C, 32'hE280_0014};
        ctrl = 32'h0000_0800;
        for (int j = 0; j < 5; j++) begin
            br = bw[j];
            run(5);
            chk("addr", 32'h0000_000C, q[3][63:32]);
            chk("next", ew[j], q[4][31:0]);
            res = 1'b1;
            @(negedge clk);
            res = 1'b0;
            chk("cancel", 32'(j == 4), 32'(cx));
            if (j == 4) begin
                chk("refetch", 32'h0000_0048, fa);
            end
            bar = 1'b1;
            @(negedge clk);
            bar = 1'b0;
            repeat (6) @(negedge clk);
        end
        $display("test predict done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        t_plain();
        t_pred();
        conclude();
    end
    initial begin
        #200us;
        err_count++;
        conclude();
    end
endmodule
